// ---- shared/mct_defs.svh ----
// Register indices, field codes and reset values of the timer front end
`ifndef MCT_DEFS_SVH
`define MCT_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_CNT_HI    14'hFA0
`define IDX_CNT_LO    14'hFA1
`define IDX_RLD_HI    14'hFA2
`define IDX_RLD_LO    14'hFA3
`define IDX_SUBADDR   14'hFA4
`define IDX_WIN0      14'hFA5
`define IDX_WIN1      14'hFA6
`define IDX_WIN2      14'hFA7

// ==========================================================
// Subaddresses of the banked registers
`define SUB_CTL       3'h0
`define SUB_CHAN      3'h1

// ==========================================================
// Reset values
`define RELOAD_RST    16'hFFFF
`define HOLD_RST      8'hFF
`define SUB_RST       3'h0
`define COUNT_RST     16'h0000
`define PRESC_RST     7'h00

// ==========================================================
// Clock source codes
`define SRC_SYS       3'h0
`define SRC_GATE_HI   3'h2
`define SRC_GATE_LO   3'h3
`define SRC_RISE      3'h4
`define SRC_FALL      3'h5

// ==========================================================
// Count mode codes
`define MODE_MOD      2'h0
`define MODE_UPDN     2'h2

// ==========================================================
// Arithmetic steps and bus answers
`define CNT_STEP      16'h0001
`define PRESC_STEP    7'h01
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define BYTE_ZERO     8'h00

`endif

// ---- shared/mct_pkg.sv ----
// Types shared by the timer front end
package mct_pkg;

  // First control register layout
  typedef struct packed {
    logic       done;       // Count cycle completed
    logic       any_chan;   // OR of channel event flags
    logic       irq_en;     // Cycle interrupt enable
    logic [1:0] rsvd;       // Reads zero
    logic [2:0] src;        // Clock source select
  } ctl0_t;

  // Second control register layout
  typedef struct packed {
    logic       run;        // Timer run enable
    logic       rsvd_hi;    // Reads zero
    logic [2:0] prescale_exponent;       // Prescale exponent
    logic       rsvd_lo;    // Reads zero
    logic [1:0] mode;       // Count mode
  } ctl1_t;

  // Up/down direction, one-hot
  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;

endpackage

// ---- design/mct_base.sv ----
// Timer front end: reload, subaddress windows, control, counter
//
// What this block does
// R1 - 16-bit reload, both bytes reset to ones
// R2 - Disabled: reload write applies next cycle
// R3 - Enabled: reload buffered until cycle end
// R4 - Period set by prescale, reload and mode
// R5 - High byte held; low write commits both
// R6 - Subaddress uses bits 2:0 only
// R7 - Software writes subaddress before window access
// R8 - Windows reach register chosen by subaddress
// R9 - Subaddress zero, window 0 is control
// R10 - Enabled: prescale write waits for cycle end
// R11 - Done flag: set on cycle, write-1 clears
// R12 - Bit 6 ORs channel flags, zero disabled
// R13 - Interrupt each cycle when bit 5 set
// R14 - Source codes: system, pin edges, reserved
// R15 - Gated sources count while pin high/low
// R16 - Pin input at most quarter clock rate
// R17 - Control bits 4:3 read zero
// R18 - Enable clear stops and resets counter
// R19 - Prescale divides by two to power
// R20 - Modulo wraps at reload; up/down bounces
// R21 - Unmapped subaddress: writes ignored, reads zero
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "mct_defs.svh"

module mct_base (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic [15:0] AWADDR,
  input  wire logic        AWVALID,
  output wire logic        AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output wire logic        WREADY,
  output logic      [1:0]  BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [15:0] ARADDR,
  input  wire logic        ARVALID,
  output wire logic        ARREADY,
  output logic      [31:0] RDATA,
  output logic      [1:0]  RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        TIMER_IN,
  input  wire logic [3:0]  CHAN_FLAGS,
  output logic      [3:0]  CHAN_FLAG_CLEAR,
  output logic      [15:0] COUNT,
  output wire logic        TIMER_RUN,
  output logic             CYCLE_IRQ
);

  // ========================================================
  // Shared decode helpers

  // Index falls inside the timer's register block
  function automatic logic is_mapped(input logic [13:0] idx);
    is_mapped = (idx >= `IDX_CNT_HI) && (idx <= `IDX_WIN2);
  endfunction

  // Low-bit mask of the prescale counter for a given exponent
  function automatic logic [6:0] prescale_exponent_mask(input logic [2:0] p);
    logic [7:0] one_hot;
    one_hot   = 8'h01 << p;
    prescale_exponent_mask = 7'(one_hot - 8'h01);
  endfunction

  // ========================================================
  // State
  logic [13:0]         aw_idx;        // Latched write index
  logic                aw_held;       // Write address taken
  logic                w_held;        // Write data taken
  logic [7:0]          w_byte;        // Latched low data byte
  logic                w_lane;        // Low byte strobe
  logic [7:0]          reload_hold;   // High byte holding
  logic [15:0]         reload_buffer; // Software view of reload
  logic [15:0]         reload_active; // Reload used by counter
  logic [2:0]          subaddr;       // Subregister selector
  mct_pkg::ctl0_t      ctl0;          // First control register
  mct_pkg::ctl1_t      ctl1;          // Second control register
  logic [2:0]          prescale_exponent_active;   // Prescale in use
  logic [6:0]          presc_cnt;     // Prescale counter
  mct_pkg::dir_t       dir;           // Up/down direction
  logic                pin_s1;        // Pin sync stage one
  logic                pin_s2;        // Pin sync stage two
  logic                pin_d;         // Pin delayed for edges

  // ========================================================
  // Write channel decode
  wire               aw_fire  = AWVALID && AWREADY;
  wire               w_fire   = WVALID && WREADY;
  wire               do_write = aw_held && w_held && !BVALID;
  wire               wr_en    = do_write && w_lane;
  wire mct_pkg::ctl0_t w_ctl0 = w_byte;
  wire mct_pkg::ctl1_t w_ctl1 = w_byte;
  wire wr_rld_hi  = wr_en && (aw_idx == `IDX_RLD_HI);
  wire wr_rld_lo  = wr_en && (aw_idx == `IDX_RLD_LO);
  wire wr_sub     = wr_en && (aw_idx == `IDX_SUBADDR);
  wire wr_win0    = wr_en && (aw_idx == `IDX_WIN0);
  wire wr_win1    = wr_en && (aw_idx == `IDX_WIN1);
  wire wr_ctl0    = wr_win0 && (subaddr == `SUB_CTL);  // R9 R8
  wire wr_ctl1    = wr_win1 && (subaddr == `SUB_CTL);  // R8
  wire wr_chan    = wr_win1 && (subaddr == `SUB_CHAN); // R8

  assign AWREADY = !aw_held;
  assign WREADY  = !w_held;

  // Address and data are taken in either order
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 14'h0000;
      w_byte  <= `BYTE_ZERO;
      w_lane  <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_idx  <= AWADDR[15:2];
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_byte <= WDATA[7:0];
        w_lane <= WSTRB[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response follows both halves
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      BVALID <= 1'b0;
      BRESP  <= `RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'b1;
      BRESP  <= is_mapped(aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // ========================================================
  // Read channel
  wire [13:0] ar_idx  = ARADDR[15:2];
  wire        ar_fire = ARVALID && ARREADY;
  wire        any_chan = TIMER_RUN && (|CHAN_FLAGS); // R12
  wire mct_pkg::ctl0_t rd_ctl0 =
    '{done: ctl0.done, any_chan: any_chan, irq_en: ctl0.irq_en,
      rsvd: 2'b00, src: ctl0.src};                   // R17
  wire [3:0]  chan_shown = TIMER_RUN ? CHAN_FLAGS : 4'h0;
  // Unmapped subaddresses read zero
  wire [7:0]  win0_byte = (subaddr == `SUB_CTL) ? rd_ctl0
                                                : `BYTE_ZERO; // R21
  wire [7:0]  win1_byte =
    (subaddr == `SUB_CTL)  ? ctl1 :
    (subaddr == `SUB_CHAN) ? {4'h0, chan_shown} : `BYTE_ZERO; // R21
  wire [7:0]  rd_byte =
    (ar_idx == `IDX_CNT_HI)  ? COUNT[15:8] :
    (ar_idx == `IDX_CNT_LO)  ? COUNT[7:0] :
    (ar_idx == `IDX_RLD_HI)  ? reload_buffer[15:8] :
    (ar_idx == `IDX_RLD_LO)  ? reload_buffer[7:0] :
    (ar_idx == `IDX_SUBADDR) ? {5'h00, subaddr} :
    (ar_idx == `IDX_WIN0)    ? win0_byte :
    (ar_idx == `IDX_WIN1)    ? win1_byte : `BYTE_ZERO;

  assign ARREADY = !RVALID;

  // Read data is registered one cycle after the address
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= `RESP_OKAY;
    end else if (ar_fire) begin
      RVALID <= 1'b1;
      RDATA  <= {24'h000000, rd_byte};
      RRESP  <= is_mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // ========================================================
  // Pin synchroniser and edge history
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_d  <= 1'b0;
    end else begin
      pin_s1 <= TIMER_IN;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  // ========================================================
  // Prescaler and count enable
  wire presc_tick = (presc_cnt & prescale_exponent_mask(prescale_exponent_active))
                    == prescale_exponent_mask(prescale_exponent_active);        // R19
  wire mode_ok = (ctl1.mode == `MODE_MOD) ||
                 (ctl1.mode == `MODE_UPDN);
  logic src_tick;                                     // Source event

  // Select what advances the counter
  always_comb begin
    case (ctl0.src)
      `SRC_SYS:     src_tick = presc_tick;            // R14
      `SRC_GATE_HI: src_tick = presc_tick && pin_s2;  // R15
      `SRC_GATE_LO: src_tick = presc_tick && !pin_s2; // R15
      `SRC_RISE:    src_tick = pin_s2 && !pin_d;      // R14 R16
      `SRC_FALL:    src_tick = !pin_s2 && pin_d;      // R14 R16
      default:      src_tick = 1'b0;                  // R14
    endcase
  end

  wire count_tick = TIMER_RUN && mode_ok && src_tick;

  // Prescale counter restarts on stop and at every cycle end, so a
  // prescale that changes at a cycle end gives a whole period at once
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      presc_cnt <= `PRESC_RST;
    end else if (!TIMER_RUN || cycle_end) begin
      presc_cnt <= `PRESC_RST;                        // R4 R10
    end else begin
      presc_cnt <= presc_cnt + `PRESC_STEP;
    end
  end

  // ========================================================
  // Counter next state
  logic [15:0]   next_count;  // Counter after a tick
  mct_pkg::dir_t next_dir;    // Direction after a tick
  logic          end_hit;     // Tick would end the cycle

  always_comb begin
    next_count = COUNT;
    next_dir   = dir;
    end_hit    = 1'b0;
    if (ctl1.mode == `MODE_MOD) begin
      // Modulo: wrap to zero after reload
      if (COUNT == reload_active) begin
        next_count = `COUNT_RST;                      // R20
        end_hit    = 1'b1;
      end else begin
        next_count = COUNT + `CNT_STEP;
      end
    end else begin
      case (dir)
        mct_pkg::DIR_UP: begin
          if (COUNT < reload_active) begin
            next_count = COUNT + `CNT_STEP;
          end else if (COUNT != `COUNT_RST) begin
            // Turn at reload
            next_count = COUNT - `CNT_STEP;           // R20
            next_dir   = (COUNT == `CNT_STEP) ? mct_pkg::DIR_UP
                                              : mct_pkg::DIR_DOWN;
            end_hit    = (COUNT == `CNT_STEP);
          end
        end
        mct_pkg::DIR_DOWN: begin
          if (COUNT == `COUNT_RST) begin
            next_dir = mct_pkg::DIR_UP;
          end else begin
            // Reaching zero ends the cycle
            next_count = COUNT - `CNT_STEP;           // R20 R13
            next_dir   = (COUNT == `CNT_STEP) ? mct_pkg::DIR_UP
                                              : mct_pkg::DIR_DOWN;
            end_hit    = (COUNT == `CNT_STEP);
          end
        end
        default: next_dir = mct_pkg::DIR_UP;
      endcase
    end
  end

  wire cycle_end = count_tick && end_hit;             // R4

  // Counter register, cleared while disabled
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      COUNT <= `COUNT_RST;
      dir   <= mct_pkg::DIR_UP;
    end else if (!TIMER_RUN) begin
      COUNT <= `COUNT_RST;                            // R18
      dir   <= mct_pkg::DIR_UP;
    end else if (count_tick) begin
      COUNT <= next_count;                            // R4 R20
      dir   <= next_dir;
    end
  end

  // ========================================================
  // Reload path
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      reload_hold   <= `HOLD_RST;                     // R1
      reload_buffer <= `RELOAD_RST;                   // R1
      reload_active <= `RELOAD_RST;                   // R1
    end else begin
      if (wr_rld_hi) begin
        reload_hold <= w_byte;                        // R5
      end
      if (wr_rld_lo) begin
        reload_buffer <= {reload_hold, w_byte};       // R5
      end
      if (!TIMER_RUN || cycle_end) begin
        reload_active <= reload_buffer;               // R2 R3
      end
    end
  end

  // ========================================================
  // Subaddress and control registers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      subaddr     <= `SUB_RST;
      ctl0        <= '0;
      ctl1        <= '0;
      prescale_exponent_active <= 3'h0;
    end else begin
      if (wr_sub) begin
        subaddr <= w_byte[2:0];                       // R6
      end
      if (wr_ctl0) begin
        ctl0.irq_en <= w_ctl0.irq_en;                 // R9
        ctl0.src    <= w_ctl0.src;
      end
      if (wr_ctl1) begin
        ctl1.run  <= w_ctl1.run;
        ctl1.prescale_exponent <= w_ctl1.prescale_exponent;
        ctl1.mode <= w_ctl1.mode;
      end
      if (!TIMER_RUN || cycle_end) begin
        // A write that starts the timer brings its own prescale
        prescale_exponent_active <= wr_ctl1 ? w_ctl1.prescale_exponent : ctl1.prescale_exponent; // R10
      end
      // Done flag: setting beats a write-1 clear
      if (!TIMER_RUN) begin
        ctl0.done <= 1'b0;                            // R11
      end else if (cycle_end) begin
        ctl0.done <= 1'b1;                            // R11
      end else if (wr_ctl0 && w_ctl0.done) begin
        ctl0.done <= 1'b0;                            // R11
      end
    end
  end

  assign TIMER_RUN = ctl1.run;

  // Interrupt pulse and channel flag clear pulses
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CYCLE_IRQ       <= 1'b0;
      CHAN_FLAG_CLEAR <= 4'h0;
    end else begin
      CYCLE_IRQ       <= cycle_end && ctl0.irq_en;    // R13
      CHAN_FLAG_CLEAR <= wr_chan ? w_byte[3:0] : 4'h0;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  property p_reload_idle;
    !TIMER_RUN |=> reload_active == $past(reload_buffer);
  endproperty
  a_reload_idle: assert property (p_reload_idle) // R2
    else $error("reload not applied while disabled");

  property p_reload_hold;
    (TIMER_RUN && !cycle_end) |=> $stable(reload_active);
  endproperty
  a_reload_hold: assert property (p_reload_hold) // R3
    else $error("reload changed mid cycle");

  property p_reload_pair;
    wr_rld_lo |=> reload_buffer ==
                  {$past(reload_hold), $past(w_byte)};
  endproperty
  a_reload_pair: assert property (p_reload_pair) // R5
    else $error("reload bytes not committed together");

  property p_prescale_exponent_hold;
    (TIMER_RUN && !cycle_end) |=> $stable(prescale_exponent_active);
  endproperty
  a_prescale_exponent_hold: assert property (p_prescale_exponent_hold) // R10
    else $error("prescale changed mid cycle");

  property p_done_set;
    (cycle_end && TIMER_RUN) |=> ctl0.done;
  endproperty
  a_done_set: assert property (p_done_set) // R11
    else $error("done flag missed a cycle end");

  property p_irq;
    (cycle_end && ctl0.irq_en) |=> CYCLE_IRQ ##1 !CYCLE_IRQ
      or (cycle_end && ctl0.irq_en);
  endproperty
  a_irq: assert property (p_irq) // R13
    else $error("cycle interrupt not raised");

  property p_stop;
    !TIMER_RUN |=> (COUNT == `COUNT_RST) && !ctl0.done;
  endproperty
  a_stop: assert property (p_stop) // R18
    else $error("counter not cleared while disabled");

  property p_wrap;
    (count_tick && ctl1.mode == `MODE_MOD &&
     COUNT == reload_active) |=> COUNT == `COUNT_RST;
  endproperty
  a_wrap: assert property (p_wrap) // R20
    else $error("modulo count did not wrap");

  property p_undivided;
    (TIMER_RUN && mode_ok && ctl0.src == `SRC_SYS &&
     prescale_exponent_active == 3'h0) |-> count_tick;
  endproperty
  a_undivided: assert property (p_undivided) // R19
    else $error("undivided clock did not count");

  property p_reserved_src;
    (ctl0.src == 3'h1 || ctl0.src > `SRC_FALL) |-> !count_tick;
  endproperty
  a_reserved_src: assert property (p_reserved_src) // R14
    else $error("reserved source counted");

  c_cycle:   cover property (cycle_end);
  c_irq:     cover property (CYCLE_IRQ);
  c_turn:    cover property (dir == mct_pkg::DIR_UP
                             ##1 dir == mct_pkg::DIR_DOWN);
  c_pin_cnt: cover property (count_tick && ctl0.src == `SRC_RISE);

endmodule // mct_base

// ---- dv/mct_pin_model.sv ----
// Far-side model: timer input pin driver and channel event flags
`timescale 1ns/1ps

module mct_pin_model #(
  parameter int HALF = 2                 // Pin half period in clocks
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        toggle_en,     // Run the pin as a clock
  input  wire logic        hold_lvl,      // Pin level while idle
  input  wire logic [3:0]  flag_set,      // Raise channel events
  input  wire logic [3:0]  flag_clr,      // Clear pulses from timer
  output logic             pin,           // Timer input pin
  output logic      [3:0]  flags,         // Channel event flags
  output logic      [15:0] rises,         // Rising edges sent
  output logic      [15:0] falls          // Falling edges sent
);
  logic [7:0] div;                        // Half period counter
  logic       wrap;                       // Half period elapsed
  logic       next_pin;                   // Pin level after this edge

  // ==========================================================
  // Pin toggles every HALF clocks, a quarter of the clock rate when HALF is 2
  assign wrap     = (div == 8'(HALF - 1));
  assign next_pin = toggle_en ? (wrap ? ~pin : pin) : hold_lvl;

  // Pin, edge counters and event flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div   <= 8'h00;
      pin   <= 1'b0;
      rises <= 16'h0000;
      falls <= 16'h0000;
      flags <= 4'h0;
    end else begin
      div   <= (toggle_en && !wrap) ? div + 8'h01 : 8'h00;
      pin   <= next_pin;
      rises <= rises + {15'h0000, next_pin & ~pin};
      falls <= falls + {15'h0000, ~next_pin & pin};
      flags <= (flags | flag_set) & ~flag_clr;
    end
  end
endmodule // mct_pin_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the timer front end
`timescale 1ns/1ps
`include "mct_defs.svh"

module tb_top;
  logic        clk, resetn;               // Clock and reset
  logic [15:0] awaddr, araddr;            // Bus addresses
  logic        awvalid, wvalid, bready;   // Write handshakes
  logic        arvalid, rready;           // Read handshakes
  logic        awready, wready, arready;  // Slave readies
  logic        bvalid, rvalid;            // Slave answers
  logic [31:0] wdata, rdata;              // Bus data
  logic [3:0]  wstrb, flags, flag_clr;    // Strobe, channel flags
  logic [3:0]  flag_set;                  // Event requests
  logic [1:0]  bresp, rresp;              // Responses
  logic        pin, run, irq;             // Pin, run, interrupt
  logic        toggle_en, hold_lvl;       // Pin model controls
  logic [15:0] count, rises, falls, r0;   // Counter, edge counts
  logic [31:0] per, pcnt, cyc;            // Period meter, timeout
  int          n_errors, comparisons;     // Verdict counters
  localparam logic [15:0] SRC_CNT = 16'h0509; // Counting sources, pin 0/1

  // ==========================================================
  // Clock and instances
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  mct_base i_dut (.SYS_CLK(clk), .RESETN(resetn), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .TIMER_IN(pin), .CHAN_FLAGS(flags),
    .CHAN_FLAG_CLEAR(flag_clr), .COUNT(count), .TIMER_RUN(run),
    .CYCLE_IRQ(irq));

  mct_pin_model i_far (.clk(clk), .resetn(resetn), .toggle_en(toggle_en),
    .hold_lvl(hold_lvl), .flag_set(flag_set), .flag_clr(flag_clr),
    .pin(pin), .flags(flags), .rises(rises), .falls(falls));

  // ==========================================================
  // Period meter between interrupt pulses, and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) begin
      per  <= pcnt;
      pcnt <= 1;
    end else pcnt <= pcnt + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end

  // ==========================================================
  // Compare and bus tasks
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t resp=%h exp=%h", $time, got, exp);
    end
  endtask

  // One byte write; response compared on arrival
  task automatic wr(input logic [13:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        done = 1'b1;
        bready <= 1'b0;
        chk_resp(bresp, er);
      end
    end
  endtask

  // One byte read; data and response compared on arrival
  task automatic rd(input logic [13:0] idx, input logic [7:0] ed,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        done = 1'b1;
        rready <= 1'b0;
        chk_data(rdata, {24'h000000, ed});
        chk_resp(rresp, er);
      end
    end
  endtask

  // Waits for an interrupt pulse and lets the meter settle
  task automatic wait_irq;
    do @(posedge clk); while (irq !== 1'b1);
    #1;
  endtask

  // Verdict and end of run
  task automatic test_done;
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {toggle_en, hold_lvl, flag_set} = '0;
    wstrb = 4'h1;
    {n_errors, comparisons} = '0;
    {per, pcnt, cyc} = '0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    // Reset contents and held high byte
    rd(`IDX_RLD_HI, 8'hFF, `RESP_OKAY);
    rd(`IDX_RLD_LO, 8'hFF, `RESP_OKAY);
    rd(`IDX_WIN0, 8'h00, `RESP_OKAY);
    wr(`IDX_RLD_HI, 8'h00, `RESP_OKAY);
    rd(`IDX_RLD_HI, 8'hFF, `RESP_OKAY);
    wr(`IDX_RLD_LO, 8'h40, `RESP_OKAY);
    rd(`IDX_RLD_HI, 8'h00, `RESP_OKAY);
    rd(`IDX_RLD_LO, 8'h40, `RESP_OKAY);
    // Selector width, empty banks, unmapped index
    wr(`IDX_SUBADDR, 8'hFD, `RESP_OKAY);
    rd(`IDX_SUBADDR, 8'h05, `RESP_OKAY);
    wstrb <= 4'h0;
    wr(`IDX_SUBADDR, 8'h03, `RESP_OKAY);
    wstrb <= 4'h1;
    rd(`IDX_SUBADDR, 8'h05, `RESP_OKAY);
    wr(`IDX_WIN0, 8'h25, `RESP_OKAY);
    rd(`IDX_WIN0, 8'h00, `RESP_OKAY);
    wr(14'h0FA8, 8'h11, `RESP_SLVERR);
    rd(14'h0FA8, 8'h00, `RESP_SLVERR);
    // Reserved bits, channel summary while stopped
    flag_set <= 4'h5;
    wr(`IDX_SUBADDR, 8'h00, `RESP_OKAY);
    flag_set <= 4'h0;
    wr(`IDX_WIN0, 8'hFF, `RESP_OKAY);
    rd(`IDX_WIN0, 8'h27, `RESP_OKAY);
    // Every clock source with the pin held low, then held high
    for (int s = 0; s < 16; s++) begin
      hold_lvl <= s[3];
      wr(`IDX_WIN0, {5'h00, s[2:0]}, `RESP_OKAY);
      wr(`IDX_WIN1, 8'h80, `RESP_OKAY);
      repeat (20) @(posedge clk);
      chk_data({31'h0, count != 16'h0}, {31'h0, SRC_CNT[s]});
      wr(`IDX_WIN1, 8'h00, `RESP_OKAY);
      repeat (2) @(posedge clk);
      chk_data({16'h0, count}, 32'h0);
    end
    hold_lvl <= 1'b0;
    // Pin edges counted one for one, prescale of four ignored
    wr(`IDX_WIN1, 8'h10, `RESP_OKAY);
    for (int e = 4; e < 6; e++) begin
      wr(`IDX_WIN0, e[7:0], `RESP_OKAY);
      wr(`IDX_WIN1, 8'h90, `RESP_OKAY);
      r0 = (e == 4) ? rises : falls;
      toggle_en <= 1'b1;
      repeat (41) @(posedge clk);
      toggle_en <= 1'b0;
      repeat (8) @(posedge clk);
      r0 = ((e == 4) ? rises : falls) - r0;
      chk_data({16'h0, count}, {16'h0, r0});
      wr(`IDX_WIN1, 8'h00, `RESP_OKAY);
    end
    // Modulo periods, buffered reload and prescale
    wr(`IDX_WIN0, 8'h20, `RESP_OKAY);
    wr(`IDX_WIN1, 8'h80, `RESP_OKAY);
    wait_irq;
    wait_irq;
    chk_data(per, 32'd65);
    wr(`IDX_RLD_HI, 8'h00, `RESP_OKAY);
    wr(`IDX_RLD_LO, 8'h10, `RESP_OKAY);
    wait_irq;
    chk_data(per, 32'd65);
    wait_irq;
    chk_data(per, 32'd17);
    wr(`IDX_WIN1, 8'h90, `RESP_OKAY);
    wait_irq;
    chk_data(per, 32'd17);
    wait_irq;
    chk_data(per, 32'd68);
    // Up/down period, status flags and channel bank
    wr(`IDX_WIN1, 8'h00, `RESP_OKAY);
    wr(`IDX_WIN1, 8'h8A, `RESP_OKAY);
    rd(`IDX_WIN1, 8'h8A, `RESP_OKAY);
    wait_irq;
    wait_irq;
    chk_data(per, 32'd64);
    rd(`IDX_WIN0, 8'hE0, `RESP_OKAY);
    wr(`IDX_WIN0, 8'hA0, `RESP_OKAY);
    rd(`IDX_WIN0, 8'h60, `RESP_OKAY);
    wr(`IDX_SUBADDR, 8'h01, `RESP_OKAY);
    rd(`IDX_WIN1, 8'h05, `RESP_OKAY);
    wr(`IDX_WIN1, 8'h05, `RESP_OKAY);
    wr(`IDX_SUBADDR, 8'h00, `RESP_OKAY);
    rd(`IDX_WIN0, 8'h20, `RESP_OKAY);
    // Stop with the done flag set
    wait_irq;
    wr(`IDX_WIN1, 8'h00, `RESP_OKAY);
    repeat (2) @(posedge clk);
    chk_data({15'h0, run, count}, 32'h0);
    rd(`IDX_CNT_LO, 8'h00, `RESP_OKAY);
    rd(`IDX_WIN0, 8'h20, `RESP_OKAY);
    test_done;
  end
endmodule // tb_top
